// File: core/rcs_pkg.sv
package rcs_pkg;

  // Core clock
  localparam int CLK_HZ          = 100_000_000;

  // Serial link: 9600 baud, 8 data bits, no parity, 1 stop bit
  localparam int BAUD_RATE       = 9600;
  localparam int BAUD_CYCLES     = CLK_HZ / BAUD_RATE;
  localparam int UART_DATA_BITS  = 8;
  localparam int UART_LAST_BIT   = UART_DATA_BITS + 1;

  // Status report interval
  localparam int REPORT_S        = 2;
  localparam int REPORT_CYCLES   = REPORT_S * CLK_HZ;

  // Remote request debounce time
  localparam int DEBOUNCE_US     = 1000;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * (CLK_HZ / 1_000_000);

  // Register byte addresses
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CONC   = 8'h04;
  localparam logic [7:0] REG_SPAN   = 8'h08;
  localparam logic [7:0] REG_ALARM  = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;

  // Control register fields and reset values
  localparam int CTRL_RNG_LSB = 0;
  localparam int CTRL_INTV    = 2;
  localparam logic [2:0]  CTRL_RESET  = 3'h0;
  localparam logic [15:0] CONC_RESET  = 16'h0000;
  localparam logic [11:0] SPAN_RESET  = 12'h100;
  localparam logic [3:0]  ALARM_RESET = 4'h0;

  // Range codes
  localparam logic [1:0] RNG_LOW  = 2'h0;
  localparam logic [1:0] RNG_MED  = 2'h1;
  localparam logic [1:0] RNG_HIGH = 2'h2;
  localparam logic [1:0] RNG_AIR  = 2'h3;

  // Characters
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;

  // Report layout: items of ten characters, CR and LF at the end
  localparam logic [2:0] ITEM_LAST = 3'h6;
  localparam logic [3:0] CI_CR     = 4'h8;
  localparam logic [3:0] CI_LF     = 4'h9;

  typedef enum logic [2:0] {
    CAL_ANALYZE = 3'b001,
    CAL_ZERO    = 3'b010,
    CAL_SPAN    = 3'b100
  } rcs_cal_t;

  typedef struct packed {
    logic sample;
    logic zero;
    logic span;
    logic exhaust;
  } rcs_valves_t;

endpackage

// File: core/rcs_ctrl.sv
// Implementation choices: the Wishbone register port and the address map.
`timescale 1ns/100ps
module rcs_ctrl
  import rcs_pkg::*;
#(
  parameter int BAUD_DIV     = BAUD_CYCLES,
  parameter int REPORT_DIV   = REPORT_CYCLES,
  parameter int DEBOUNCE_DIV = DEBOUNCE_CYCLES
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Remote calibration
  input  wire logic        remote_zero_req,
  input  wire logic        remote_span_req,
  input  wire logic        cal_done,
  output logic             cal_busy_contact,
  // Range relays and valves
  output logic      [3:0]  range_relay,
  output rcs_valves_t      ext_valves,
  output rcs_valves_t      int_valves,
  // Serial link
  input  wire logic        serial_rx,
  output logic             serial_tx
);

  function automatic logic [7:0] digit(input logic [3:0] n);
    return {4'h3, n};
  endfunction

  function automatic logic [7:0] item_char(input logic [2:0]  it,
                                           input logic [3:0]  ci,
                                           input logic [15:0] cc,
                                           input logic [11:0] sp,
                                           input logic [1:0]  rg);
    logic [63:0] nm;
    logic [7:0]  c;
    nm = 64'h0;
    c  = 8'h00;
    case (it)
      3'h0: nm = {digit(cc[15:12]), digit(cc[11:8]), ".",
                  digit(cc[7:4]), digit(cc[3:0]), "%", 16'h0000};
      3'h1: begin
        case (rg)
          RNG_LOW:  nm = {"LO", 48'h0};
          RNG_MED:  nm = {"MED", 40'h0};
          RNG_HIGH: nm = {"HI", 48'h0};
          default:  nm = {"AIR", 40'h0};
        endcase
      end
      3'h2: nm = {"0-", digit(sp[11:8]), digit(sp[7:4]),
                  digit(sp[3:0]), "%", 16'h0000};
      3'h3: nm = "AL-1 DIS";
      3'h4: nm = "AL-2 DIS";
      3'h5: nm = {"AL-1 ON", 8'h00};
      default: nm = {"AL-2 ON", 8'h00};
    endcase
    if (ci == CI_CR) begin
      c = CH_CR;
    end else if (ci == CI_LF) begin
      c = CH_LF;
    end else begin
      c = nm[{~ci[2:0], 3'b000} +: 8];
    end
    return c;
  endfunction

  // Registers
  logic [2:0]  ctrl_q;
  logic [15:0] conc_q;
  logic [11:0] span_q;
  logic [3:0]  alm_q;
  logic        ack_q;
  logic [31:0] dat_q;
  logic        wb_acc;
  logic        wb_wr;
  logic [7:0]  wb_word;

  assign wb_acc  = wb_cyc_i & wb_stb_i;
  assign wb_wr   = wb_acc & wb_we_i & ack_q;
  assign wb_word = {wb_adr_i[7:2], 2'b00};

  // Request synchronisers and debounce
  logic [1:0] req_s1_q;
  logic [1:0] req_s2_q;
  logic [1:0] req_db;

  // Calibration state
  rcs_cal_t   cal_q;
  rcs_cal_t   cal_d;
  logic       cal_busy_q;
  logic [3:0] relay_q;
  rcs_valves_t ext_q;
  rcs_valves_t int_q;

  // Serial receive and commands
  logic        rx_s1_q;
  logic        rx_s2_q;
  logic        rx_busy_q;
  logic [31:0] rx_cnt_q;
  logic [3:0]  rx_bit_q;
  logic [7:0]  rx_sh_q;
  logic        rx_valid_q;
  logic [1:0]  cmd_n_q;
  logic [7:0]  cmd_c0_q;
  logic [7:0]  cmd_c1_q;
  logic        cmd_zero_q;
  logic        cmd_span_q;
  logic        cmd_stat_q;
  logic        stat_en_q;

  // Report and transmit
  logic [31:0] tmr_q;
  logic        rep_act_q;
  logic [2:0]  item_q;
  logic [3:0]  ci_q;
  logic [7:0]  tx_ch;
  logic        item_on;
  logic        tx_go;
  logic        tx_busy_q;
  logic [9:0]  tx_sh_q;
  logic [31:0] tx_cnt_q;
  logic [3:0]  tx_bit_q;
  logic        tx_line_q;

  // Bus slave: ack one cycle after request, write at the acked edge
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= wb_acc & ~ack_q;
      if (wb_acc & ~ack_q) begin
        case (wb_word)
          REG_CTRL:   dat_q <= {29'h0, ctrl_q};
          REG_CONC:   dat_q <= {16'h0000, conc_q};
          REG_SPAN:   dat_q <= {20'h0_0000, span_q};
          REG_ALARM:  dat_q <= {28'h000_0000, alm_q};
          REG_STATUS: dat_q <= {27'h000_0000, tx_busy_q, stat_en_q,
                                cal_q == CAL_SPAN, cal_q == CAL_ZERO,
                                cal_busy_q};
          default:    dat_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_q <= CTRL_RESET;
      conc_q <= CONC_RESET;
      span_q <= SPAN_RESET;
      alm_q  <= ALARM_RESET;
    end else if (wb_wr) begin
      if (wb_word == REG_CTRL && wb_sel_i[0]) ctrl_q <= wb_dat_i[2:0];
      if (wb_word == REG_CONC && wb_sel_i[0]) conc_q[7:0] <= wb_dat_i[7:0];
      if (wb_word == REG_CONC && wb_sel_i[1]) conc_q[15:8] <= wb_dat_i[15:8];
      if (wb_word == REG_SPAN && wb_sel_i[0]) span_q[7:0] <= wb_dat_i[7:0];
      if (wb_word == REG_SPAN && wb_sel_i[1]) span_q[11:8] <= wb_dat_i[11:8];
      if (wb_word == REG_ALARM && wb_sel_i[0]) alm_q <= wb_dat_i[3:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      req_s1_q <= 2'h0;
      req_s2_q <= 2'h0;
    end else begin
      req_s1_q <= {remote_span_req, remote_zero_req};
      req_s2_q <= req_s1_q;
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_deb
    logic [31:0] cnt_q;
    logic        db_q;
    // Level must hold steady for the whole debounce time
    always_ff @(posedge core_clk) begin
      if (reset) begin
        cnt_q <= 32'h0000_0000;
        db_q  <= 1'b0;
      end else if (req_s2_q[i] == db_q) begin
        cnt_q <= 32'h0000_0000;
      end else if (cnt_q == 32'(DEBOUNCE_DIV - 1)) begin
        cnt_q <= 32'h0000_0000;
        db_q  <= req_s2_q[i];
      end else begin
        cnt_q <= cnt_q + 32'h0000_0001;
      end
    end
    assign req_db[i] = db_q;
  end

  // Requests are only looked at in analyze; a finished calibration
  // returns to analyze for one cycle, so a held request runs again.
  always_comb begin
    cal_d = cal_q;
    unique case (cal_q)
      CAL_ANALYZE: begin
        if (req_db[0] | cmd_zero_q) begin
          cal_d = CAL_ZERO;
        end else if (req_db[1] | cmd_span_q) begin
          cal_d = CAL_SPAN;
        end
      end
      CAL_ZERO, CAL_SPAN: begin
        if (cal_done) cal_d = CAL_ANALYZE;
      end
      default: cal_d = CAL_ANALYZE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cal_q      <= CAL_ANALYZE;
      cal_busy_q <= 1'b0;
    end else begin
      cal_q      <= cal_d;
      cal_busy_q <= cal_d != CAL_ANALYZE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      relay_q <= 4'h0;
      ext_q   <= '0;
      int_q   <= '0;
    end else begin
      relay_q <= 4'(4'h1 << ctrl_q[CTRL_RNG_LSB +: 2]);
      ext_q.sample  <= cal_d == CAL_ANALYZE;
      ext_q.zero    <= cal_d == CAL_ZERO;
      ext_q.span    <= cal_d == CAL_SPAN;
      ext_q.exhaust <= 1'b1;
      int_q.sample  <= ctrl_q[CTRL_INTV] & (cal_d == CAL_ANALYZE);
      int_q.zero    <= ctrl_q[CTRL_INTV] & (cal_d == CAL_ZERO);
      int_q.span    <= ctrl_q[CTRL_INTV] & (cal_d == CAL_SPAN);
      int_q.exhaust <= ctrl_q[CTRL_INTV];
    end
  end

  // Receiver: samples mid-bit, drops false starts and bad stop bits
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rx_s1_q    <= 1'b1;
      rx_s2_q    <= 1'b1;
      rx_busy_q  <= 1'b0;
      rx_cnt_q   <= 32'h0000_0000;
      rx_bit_q   <= 4'h0;
      rx_sh_q    <= 8'h00;
      rx_valid_q <= 1'b0;
    end else begin
      rx_s1_q    <= serial_rx;
      rx_s2_q    <= rx_s1_q;
      rx_valid_q <= 1'b0;
      if (!rx_busy_q) begin
        if (!rx_s2_q) begin
          rx_busy_q <= 1'b1;
          rx_cnt_q  <= 32'(BAUD_DIV / 2);
          rx_bit_q  <= 4'h0;
        end
      end else if (rx_cnt_q != 32'h0000_0000) begin
        rx_cnt_q <= rx_cnt_q - 32'h0000_0001;
      end else begin
        rx_cnt_q <= 32'(BAUD_DIV - 1);
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q == 4'h0 && rx_s2_q) begin
          rx_busy_q <= 1'b0;
        end else if (rx_bit_q == 4'(UART_LAST_BIT)) begin
          rx_busy_q  <= 1'b0;
          rx_valid_q <= rx_s2_q;
        end else if (rx_bit_q != 4'h0) begin
          rx_sh_q <= {rx_s2_q, rx_sh_q[7:1]};
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cmd_n_q    <= 2'h0;
      cmd_c0_q   <= 8'h00;
      cmd_c1_q   <= 8'h00;
      cmd_zero_q <= 1'b0;
      cmd_span_q <= 1'b0;
      cmd_stat_q <= 1'b0;
    end else begin
      cmd_zero_q <= 1'b0;
      cmd_span_q <= 1'b0;
      cmd_stat_q <= 1'b0;
      if (rx_valid_q) begin
        if (rx_sh_q == CH_CR) begin
          cmd_n_q <= 2'h0;
          if (cmd_n_q == 2'h2 && cmd_c0_q == "a") begin
            cmd_zero_q <= cmd_c1_q == "z";
            cmd_span_q <= cmd_c1_q == "s";
          end
          cmd_stat_q <= cmd_n_q == 2'h2 && {cmd_c0_q, cmd_c1_q} == "st";
        end else if (cmd_n_q == 2'h0) begin
          cmd_c0_q <= rx_sh_q;
          cmd_n_q  <= 2'h1;
        end else if (cmd_n_q == 2'h1) begin
          cmd_c1_q <= rx_sh_q;
          cmd_n_q  <= 2'h2;
        end else begin
          cmd_n_q  <= 2'h3;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      stat_en_q <= 1'b1;
    end else if (cmd_stat_q) begin
      stat_en_q <= ~stat_en_q;
    end
  end

  // Report sequencer walks items; absent characters are skipped
  assign tx_ch   = item_char(item_q, ci_q, conc_q, span_q,
                             ctrl_q[CTRL_RNG_LSB +: 2]);
  assign item_on = (item_q < 3'h3) | alm_q[2'(item_q - 3'h3)];
  assign tx_go   = rep_act_q & ~tx_busy_q & item_on & (tx_ch != 8'h00);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tmr_q     <= 32'h0000_0000;
      rep_act_q <= 1'b0;
      item_q    <= 3'h0;
      ci_q      <= 4'h0;
    end else begin
      if (tmr_q == 32'(REPORT_DIV - 1)) begin
        tmr_q <= 32'h0000_0000;
        if (stat_en_q && !rep_act_q) begin
          rep_act_q <= 1'b1;
          item_q    <= 3'h0;
          ci_q      <= 4'h0;
        end
      end else begin
        tmr_q <= tmr_q + 32'h0000_0001;
      end
      if (rep_act_q && !stat_en_q) begin
        rep_act_q <= 1'b0;
      end else if (rep_act_q && !tx_busy_q) begin
        if (ci_q == CI_LF || !item_on) begin
          ci_q   <= 4'h0;
          item_q <= item_q + 3'h1;
          if (item_q == ITEM_LAST) rep_act_q <= 1'b0;
        end else begin
          ci_q <= ci_q + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_busy_q <= 1'b0;
      tx_sh_q   <= 10'h3FF;
      tx_cnt_q  <= 32'h0000_0000;
      tx_bit_q  <= 4'h0;
      tx_line_q <= 1'b1;
    end else begin
      tx_line_q <= tx_busy_q ? tx_sh_q[0] : 1'b1;
      if (tx_go) begin
        tx_busy_q <= 1'b1;
        tx_sh_q   <= {1'b1, tx_ch, 1'b0};
        tx_cnt_q  <= 32'(BAUD_DIV - 1);
        tx_bit_q  <= 4'h0;
      end else if (tx_busy_q) begin
        if (tx_cnt_q != 32'h0000_0000) begin
          tx_cnt_q <= tx_cnt_q - 32'h0000_0001;
        end else begin
          tx_cnt_q <= 32'(BAUD_DIV - 1);
          tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
          tx_bit_q <= tx_bit_q + 4'h1;
          if (tx_bit_q == 4'(UART_LAST_BIT)) tx_busy_q <= 1'b0;
        end
      end
    end
  end

  assign wb_dat_o         = dat_q;
  assign wb_ack_o         = ack_q;
  assign cal_busy_contact = cal_busy_q;
  assign range_relay      = relay_q;
  assign ext_valves       = ext_q;
  assign int_valves       = int_q;
  assign serial_tx        = tx_line_q;

  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_zero_done_held;
    cal_q == CAL_ZERO && cal_done && req_db[0] ##1 req_db[0];
  endsequence

  sequence s_span_done_held;
    cal_q == CAL_SPAN && cal_done && !req_db[0] && req_db[1]
    ##1 !req_db[0] && req_db[1];
  endsequence

  a_zero_req_start: assert property (
    cal_q == CAL_ANALYZE && req_db[0] |=> cal_q == CAL_ZERO && cal_busy_q)
    else $error("zero request did not start zero calibration");
  a_span_req_start: assert property (
    cal_q == CAL_ANALYZE && !req_db[0] && !cmd_zero_q && req_db[1]
    |=> cal_q == CAL_SPAN)
    else $error("span request did not start span calibration");
  a_cal_done_opens: assert property (
    cal_q != CAL_ANALYZE && cal_done |=> !cal_busy_q && ext_q.sample)
    else $error("busy contact not open after completion");
  a_busy_contact: assert property (
    cal_busy_q == (cal_q != CAL_ANALYZE))
    else $error("busy contact disagrees with calibration state");
  a_no_queue: assert property (
    cal_q != CAL_ANALYZE && !cal_done |=> $stable(cal_q))
    else $error("running calibration changed without completion");
  a_held_repeats: assert property (
    s_zero_done_held |=> cal_q == CAL_ZERO && cal_busy_q)
    else $error("held zero request did not repeat calibration");
  a_span_repeats: assert property (
    s_span_done_held |=> cal_q == CAL_SPAN && cal_busy_q)
    else $error("held span request did not repeat calibration");
  a_range_relay: assert property (
    !$past(reset) |-> $onehot(relay_q) && relay_q[$past(ctrl_q[1:0])])
    else $error("range relay does not match range");
  a_ext_valves: assert property (
    ext_q.zero == (cal_q == CAL_ZERO) && ext_q.span == (cal_q == CAL_SPAN))
    else $error("external valves out of step with state");
  a_int_valves: assert property (
    !ctrl_q[CTRL_INTV] ##1 !ctrl_q[CTRL_INTV] |-> int_q == '0)
    else $error("internal valves driven without option");
  a_report_tick: assert property (
    tmr_q == 32'(REPORT_DIV - 1) && stat_en_q |=> rep_act_q)
    else $error("status report not started at interval");
  a_crlf_end: assert property (
    tx_go && ci_q == CI_CR
    |-> tx_ch == CH_CR ##1 tx_busy_q && (ci_q == CI_LF || !rep_act_q))
    else $error("item not ended by carriage return");
  a_toggle_stat: assert property (
    cmd_stat_q |=> stat_en_q != $past(stat_en_q))
    else $error("status toggle command had no effect");
  a_tx_frame: assert property (
    tx_go |=> tx_busy_q && !tx_sh_q[0] && tx_sh_q[9])
    else $error("transmit frame without start or stop bit");
  a_cmd_after_cr: assert property (
    cmd_zero_q || cmd_span_q |-> $past(rx_valid_q && rx_sh_q == CH_CR))
    else $error("command accepted without carriage return");

endmodule

// File: tb/rcs_far_end.sv
`timescale 1ns/100ps
module rcs_far_end
  import rcs_pkg::*;
#(
  parameter int BAUD_DIV = 16
) (
  // Clock
  input  wire logic core_clk,
  // Remote calibration
  input  wire logic cal_busy_contact,
  output logic      remote_zero_req,
  output logic      remote_span_req,
  // Serial link
  input  wire logic serial_tx,
  output logic      serial_rx
);
  logic [7:0] rx_q[$];
  logic [7:0] sh_q;

  initial begin
    remote_zero_req = 1'b0;
    remote_span_req = 1'b0;
    serial_rx       = 1'b1;
  end

  // Request held until the contact closes, then released
  task automatic press(input bit span);
    int n;
    n = 0;
    @(posedge core_clk);
    remote_span_req <= span;
    remote_zero_req <= !span;
    @(posedge core_clk);
    while (cal_busy_contact !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    remote_zero_req <= 1'b0;
    remote_span_req <= 1'b0;
  endtask

  // Request held for a fixed time whatever the contact does
  task automatic pulse(input bit span, input int n);
    @(posedge core_clk);
    remote_span_req <= span;
    remote_zero_req <= !span;
    repeat (n) @(posedge core_clk);
    remote_zero_req <= 1'b0;
    remote_span_req <= 1'b0;
  endtask

  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge core_clk);
      serial_rx <= f[i];
      repeat (BAUD_DIV - 1) @(posedge core_clk);
    end
  endtask

  // Character decoder, mid-bit sampling, LSB first
  always begin
    @(negedge serial_tx);
    repeat (BAUD_DIV / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BAUD_DIV) @(posedge core_clk);
      sh_q[i] = serial_tx;
    end
    repeat (BAUD_DIV) @(posedge core_clk);
    if (serial_tx === 1'b1) rx_q.push_back(sh_q);
  end
endmodule

// File: tb/test_rcs_ctrl.sv
`timescale 1ns/100ps
module test_rcs_ctrl
  import rcs_pkg::*;
;
  localparam int BDIV = 16;
  localparam int RDIV = 8000;
  logic        core_clk;
  logic        reset;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        zreq;
  logic        sreq;
  logic        cal_done;
  logic        cal_busy_contact;
  logic [3:0]  range_relay;
  rcs_valves_t ext_valves;
  rcs_valves_t int_valves;
  logic        serial_rx;
  logic        serial_tx;
  int          fails;
  int          n_checks;
  int          cycles;
  logic [15:0] conc;
  string       exp_s;
  string       got_s;
  bit          found;

  rcs_ctrl #(.BAUD_DIV(BDIV), .REPORT_DIV(RDIV), .DEBOUNCE_DIV(4)) u_rcs_ctrl (
    .core_clk(core_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .remote_zero_req(zreq), .remote_span_req(sreq),
    .cal_done(cal_done), .cal_busy_contact(cal_busy_contact),
    .range_relay(range_relay), .ext_valves(ext_valves),
    .int_valves(int_valves), .serial_rx(serial_rx), .serial_tx(serial_tx));

  rcs_far_end #(.BAUD_DIV(BDIV)) far_end (
    .core_clk(core_clk), .cal_busy_contact(cal_busy_contact),
    .remote_zero_req(zreq), .remote_span_req(sreq),
    .serial_tx(serial_tx), .serial_rx(serial_rx));

  always #5 core_clk = ~core_clk;

  task automatic tally_and_finish();
    if (fails == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 80000) begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wb(input bit we, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge core_clk);
    while (wb_ack_o !== 1'b1) begin
      @(posedge core_clk);
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask

  // Mode 0 analyze, 1 zero, 2 span: contact and valve pattern
  task automatic chk_mode(input int m);
    logic [3:0] v;
    v = (m == 0) ? 4'h9 : (m == 1) ? 4'h5 : 4'h3;
    @(negedge core_clk);
    chk({31'h0, cal_busy_contact}, {31'h0, m != 0});
    chk({28'h0, ext_valves}, {28'h0, v});
  endtask

  task automatic wait_busy();
    int n;
    n = 0;
    while (cal_busy_contact !== 1'b1 && n < 400) begin
      @(posedge core_clk);
      n++;
    end
  endtask

  task automatic done_pulse();
    @(posedge core_clk);
    cal_done <= 1'b1;
    @(posedge core_clk);
    cal_done <= 1'b0;
  endtask

  task automatic cmd(input logic [7:0] a, input logic [7:0] b);
    far_end.send_byte(a);
    far_end.send_byte(b);
    far_end.send_byte(CH_CR);
  endtask

  initial begin
    core_clk = 1'b0;
    reset    = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0000_0000;
    cal_done = 1'b0;
    fails    = 0;
    n_checks = 0;
    cycles   = 0;
    void'($urandom(32'h5201_1011));
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    chk_mode(0);
    rd(REG_SPAN, 32'h0000_0100);
    rd(8'h1C, 32'h0000_0000);
    for (int r = 0; r < 4; r++) begin
      wr(REG_CTRL, r);
      rd(REG_CTRL, r);
      @(negedge core_clk);
      chk({28'h0, range_relay}, 32'h1 << r);
    end
    wr(REG_CTRL, 32'h0000_0004);
    far_end.pulse(1'b0, 2);
    repeat (20) @(posedge core_clk);
    chk_mode(0);
    far_end.press(1'b0);
    chk_mode(1);
    chk({30'h0, int_valves.zero, int_valves.span}, 32'h2);
    rd(REG_STATUS, 32'h0000_000B);
    far_end.pulse(1'b1, 20);
    // Let the debounced span level clear before completion
    repeat (10) @(posedge core_clk);
    done_pulse();
    chk_mode(0);
    repeat (30) @(posedge core_clk);
    chk_mode(0);
    fork
      far_end.pulse(1'b1, 60);
      begin
        wait_busy();
        chk_mode(2);
        done_pulse();
        @(negedge core_clk);
        chk({31'h0, cal_busy_contact}, 32'h0);
        wait_busy();
        chk_mode(2);
      end
    join
    repeat (10) @(posedge core_clk);
    done_pulse();
    chk_mode(0);
    cmd("a", "z");
    wait_busy();
    chk_mode(1);
    done_pulse();
    cmd("a", "s");
    wait_busy();
    chk_mode(2);
    chk({30'h0, int_valves.zero, int_valves.span}, 32'h1);
    done_pulse();
    cmd("a", "x");
    far_end.send_byte("z");
    cmd("a", "z");
    repeat (40) @(posedge core_clk);
    chk_mode(0);
    for (int i = 0; i < 4; i++) conc[i*4 +: 4] = 4'($urandom % 10);
    wr(REG_CONC, {16'h0, conc});
    wr(REG_ALARM, 32'h0000_0005);
    wr(REG_CTRL, 32'h0000_0001);
    exp_s = $sformatf({"%h.%h%%\015\012MED\015\0120-100%%\015\012",
                       "AL-1 DIS\015\012AL-1 ON\015\012"},
                      conc[15:8], conc[7:0]);
    far_end.rx_q.delete();
    repeat (2 * RDIV) @(posedge core_clk);
    got_s = "";
    foreach (far_end.rx_q[i]) got_s = {got_s, string'(far_end.rx_q[i])};
    found = 1'b0;
    for (int i = 0; i + exp_s.len() <= got_s.len(); i++) begin
      if (got_s.substr(i, i + exp_s.len() - 1) == exp_s) found = 1'b1;
    end
    chk({31'h0, found}, 32'h1);
    cmd("s", "t");
    repeat (200) @(posedge core_clk);
    far_end.rx_q.delete();
    repeat (2 * RDIV) @(posedge core_clk);
    chk(far_end.rx_q.size(), 32'h0);
    cmd("s", "t");
    far_end.rx_q.delete();
    repeat (2 * RDIV) @(posedge core_clk);
    chk({31'h0, far_end.rx_q.size() >= exp_s.len()}, 32'h1);
    tally_and_finish();
  end
endmodule
